// ### core/iprb_buffer.sv
`timescale 1ns/1ps
module iprb_buffer #(
	parameter int ENTRIES = iprb_pkg::IPRB_ENTRIES,
	parameter int ADDR_W  = iprb_pkg::IPRB_ADDR_W
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// Bundle pair hints
	input  wire logic              hint0Valid,
	input  wire logic [1:0]        hint0Slot,
	input  wire logic [ADDR_W-1:0] hint0Addr,
	input  wire iprb_pkg::iprb_compl_t hint0Compl0,
	input  wire iprb_pkg::iprb_compl_t hint0Compl1,
	input  wire logic              hint1Valid,
	input  wire logic [1:0]        hint1Slot,
	input  wire logic [ADDR_W-1:0] hint1Addr,
	input  wire iprb_pkg::iprb_compl_t hint1Compl0,
	input  wire iprb_pkg::iprb_compl_t hint1Compl1,
	// Branch register move in the execute-detect stage
	input  wire logic              moveValid,
	input  wire logic [ADDR_W-1:0] moveAddr,
	// Front-end branch prediction
	input  wire logic              branchValid,
	input  wire logic              branchTaken,
	// First-level icache and translation lookup of the issuing entry
	output logic                   lookupValid,
	output logic [ADDR_W-1:0]      lookupAddr,
	input  wire logic              icacheHit,
	input  wire logic              itlbMiss,
	// Mid-level icache request
	output logic                   midReqValid,
	output logic [ADDR_W-1:0]      midReqAddr,
	input  wire logic              midReqReady,
	// Streaming engine wide-hint vector
	input  wire logic              streamActive,
	input  wire logic [1:0]        streamTrace,
	input  wire logic [1:0]        streamDc,
	output logic                   streamCancel,
	// Status
	output logic [ENTRIES-1:0]     entryValid,
	output logic [ENTRIES-1:0]     entryReady,
	output logic                   cancelPulse
);
	import iprb_pkg::*;

	localparam int IDX_W = $clog2(ENTRIES);

	// ----------------------------------------
	// Entry storage
	// ----------------------------------------
	logic [ENTRIES-1:0]      valid_reg, valid_next;
	logic [ADDR_W-1:0]       addr_reg [ENTRIES], addr_next [ENTRIES];
	logic [1:0]              trace_reg [ENTRIES], trace_next [ENTRIES];
	logic [1:0]              dc_reg [ENTRIES], dc_next [ENTRIES];
	logic [1:0]              age_reg [ENTRIES], age_next [ENTRIES];
	logic [1:0]              trUpd [ENTRIES], dcUpd [ENTRIES], agUpd [ENTRIES];
	logic [ENTRIES-1:0]      mism;
	logic [1:0]              sTr_reg, sTr_next, sDc_reg, sDc_next, sAg_reg, sAg_next;
	logic                    sMis;
	logic [1:0]              sTrUpd, sDcUpd, sAgUpd;
	logic                    sAct_reg, sAct_next;
	logic                    cancel_reg, cancel_next;
	logic                    midV_reg, midV_next;
	logic [ADDR_W-1:0]       midA_reg, midA_next;

	// Only slot-2 hints count as sources.
	logic h0, h1;
	assign h0 = hint0Valid && (hint0Slot == 2'(IPRB_HINT_SLOT));
	assign h1 = hint1Valid && (hint1Slot == 2'(IPRB_HINT_SLOT));

	logic      p0V, p1V;
	iprb_src_t p0S, p1S;

	iprb_port_arbiter u_arb (
		.hint0Valid (h0),
		.hint1Valid (h1),
		.moveValid  (moveValid),
		.port0Valid (p0V),
		.port0Src   (p0S),
		.port1Valid (p1V),
		.port1Src   (p1S)
	);

	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : g_chk
			iprb_trace_check u_chk (
				.traceIn     (trace_reg[g]),
				.dcIn        (dc_reg[g]),
				.ageIn       (age_reg[g]),
				.branchValid (branchValid && valid_reg[g]),
				.branchTaken (branchTaken),
				.traceOut    (trUpd[g]),
				.dcOut       (dcUpd[g]),
				.ageOut      (agUpd[g]),
				.mismatch    (mism[g])
			);
			assign entryReady[g] = valid_reg[g] && (&age_reg[g]);
		end
	endgenerate

	iprb_trace_check u_stream (
		.traceIn     (sTr_reg),
		.dcIn        (sDc_reg),
		.ageIn       (sAg_reg),
		.branchValid (branchValid && sAct_reg),
		.branchTaken (branchTaken),
		.traceOut    (sTrUpd),
		.dcOut       (sDcUpd),
		.ageOut      (sAgUpd),
		.mismatch    (sMis)
	);

	// Lowest ready entry is presented for lookup.
	logic [IDX_W-1:0] issIdx;
	logic             issAny;
	always_comb begin
		issIdx = '0;
		issAny = 1'b0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (entryReady[i] && !mism[i]) begin
				issIdx = IDX_W'(i);
				issAny = 1'b1;
			end
		end
	end

	assign lookupValid = issAny && !midV_reg;
	assign lookupAddr  = addr_reg[issIdx];
	assign entryValid  = valid_reg;
	assign midReqValid = midV_reg;
	assign midReqAddr  = midA_reg;
	assign streamCancel = cancel_reg;
	assign cancelPulse  = cancel_reg;

	function automatic logic [1:0] dcBits(input iprb_compl_t c1, input iprb_compl_t c0);
		dcBits = {c1 == IPRB_DONT_CARE, c0 == IPRB_DONT_CARE};
	endfunction

	function automatic logic [1:0] tkBits(input iprb_compl_t c1, input iprb_compl_t c0);
		tkBits = {c1 == IPRB_TAKEN, c0 == IPRB_TAKEN};
	endfunction

	always_comb begin
		logic [ADDR_W-1:0] wA [2];
		logic [1:0]        wT [2];
		logic [1:0]        wD [2];
		logic [1:0]        wV;
		logic [1:0]        done;
		logic              anyCancel;
		logic              placed;
		iprb_src_t         s;
		wA = '{default: '0};
		wT = '{default: '0};
		wD = '{default: '0};
		placed = 1'b0;
		s = IPRB_SRC_HINT0;
		wV = {p1V, p0V};
		done = 2'b00;
		anyCancel = 1'b0;
		for (int p = 0; p < 2; p++) begin
			s = (p == 0) ? p0S : p1S;
			unique case (s)
				IPRB_SRC_HINT0: begin
					wA[p] = hint0Addr;
					wT[p] = tkBits(hint0Compl1, hint0Compl0);
					wD[p] = dcBits(hint0Compl1, hint0Compl0);
				end
				IPRB_SRC_HINT1: begin
					wA[p] = hint1Addr;
					wT[p] = tkBits(hint1Compl1, hint1Compl0);
					wD[p] = dcBits(hint1Compl1, hint1Compl0);
				end
				default: begin
					wA[p] = moveAddr;
					wT[p] = 2'h0;
					wD[p] = 2'h3;
				end
			endcase
		end
		for (int i = 0; i < ENTRIES; i++) begin
			valid_next[i] = valid_reg[i] && !mism[i]; // Freed at once.
			addr_next[i]  = addr_reg[i];
			trace_next[i] = trUpd[i];
			dc_next[i]    = dcUpd[i];
			age_next[i]   = agUpd[i];
			anyCancel     = anyCancel | (valid_reg[i] & mism[i]);
		end
		midV_next = midV_reg && !midReqReady;
		midA_next = midA_reg;
		if (lookupValid) begin
			valid_next[issIdx] = 1'b0;
			if (itlbMiss) begin
				anyCancel = 1'b1; // Translation miss cancels.
			end else if (!icacheHit) begin
				midV_next = 1'b1; // Only misses go on.
				midA_next = addr_reg[issIdx];
			end
		end
		// Two free slots at most are taken per cycle.
		// One port per free slot, so port 1 never lands on the slot port 0 just took.
		for (int i = 0; i < ENTRIES; i++) begin
			placed = 1'b0;
			if (!valid_reg[i]) begin
				for (int p = 0; p < 2; p++) begin
					if (!placed && wV[p] && !done[p] && !(p == 1 && wV[0] && !done[0])) begin
						valid_next[i] = 1'b1;
						addr_next[i]  = wA[p];
						trace_next[i] = wT[p];
						dc_next[i]    = wD[p];
						age_next[i]   = IPRB_AGE_RST | wD[p];
						done[p]       = 1'b1;
						placed        = 1'b1;
					end
				end
			end
		end
		cancel_next = anyCancel;
		sAct_next = streamActive && !sMis;
		sTr_next  = sAct_reg ? sTrUpd : streamTrace;
		sDc_next  = sAct_reg ? sDcUpd : streamDc;
		sAg_next  = sAct_reg ? sAgUpd : streamDc;
		if (sAct_reg && sMis) begin
			cancel_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			valid_reg  <= '0;
			midV_reg   <= 1'b0;
			midA_reg   <= '0;
			cancel_reg <= 1'b0;
			sAct_reg   <= 1'b0;
			sTr_reg    <= 2'h0;
			sDc_reg    <= 2'h0;
			sAg_reg    <= IPRB_AGE_RST;
			for (int i = 0; i < ENTRIES; i++) begin
				addr_reg[i]  <= '0;
				trace_reg[i] <= 2'h0;
				dc_reg[i]    <= 2'h0;
				age_reg[i]   <= IPRB_AGE_RST;
			end
		end else begin
			valid_reg  <= valid_next;
			midV_reg   <= midV_next;
			midA_reg   <= midA_next;
			cancel_reg <= cancel_next;
			sAct_reg   <= sAct_next;
			sTr_reg    <= sTr_next;
			sDc_reg    <= sDc_next;
			sAg_reg    <= sAg_next;
			for (int i = 0; i < ENTRIES; i++) begin
				addr_reg[i]  <= addr_next[i];
				trace_reg[i] <= trace_next[i];
				dc_reg[i]    <= dc_next[i];
				age_reg[i]   <= age_next[i];
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	hit_no_fwd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		lookupValid && icacheHit && !midReqValid |=> !midReqValid)
		else $error("icache hit forwarded");
	tlb_cancel_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		lookupValid && itlbMiss |=> cancelPulse)
		else $error("tlb miss not cancelled");
	miss_fwd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		lookupValid && !icacheHit && !itlbMiss |=> midReqValid)
		else $error("miss not forwarded");
	ready_age_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		lookupValid |-> &age_reg[issIdx])
		else $error("issue before aged");
	mism_free_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		valid_reg[0] && mism[0] |=> !valid_reg[0])
		else $error("mismatch not freed");
	two_writes_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		$countones(valid_reg) <= $countones($past(valid_reg)) + 2)
		else $error("more than two writes");
	none_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!h0 && !h1 && !moveValid |=> $countones(valid_reg) <= $countones($past(valid_reg)))
		else $error("write without request");
	stream_cancel_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		sAct_reg && sMis |=> streamCancel)
		else $error("stream not cancelled");
	drop_hint1_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		h0 && h1 && moveValid |-> p0V && p1V && p0S == IPRB_SRC_HINT0 && p1S == IPRB_SRC_MOVE)
		else $error("bundle-1 hint kept over move");
endmodule // iprb_buffer

// ### core/iprb_pkg.sv
package iprb_pkg;

	// ----------------------------------------
	// Sizes and reset values
	// ----------------------------------------
	localparam int IPRB_ENTRIES  = 8;
	localparam int IPRB_ADDR_W   = 64;
	localparam int IPRB_VEC_W    = 2;
	localparam int IPRB_HINT_SLOT = 2;
	localparam logic [1:0] IPRB_AGE_RST = 2'h0;

	// ----------------------------------------
	// Completer and source encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		IPRB_NOT_TAKEN = 2'b00,
		IPRB_TAKEN     = 2'b01,
		IPRB_DONT_CARE = 2'b10
	} iprb_compl_t;

	typedef enum logic [1:0] {
		IPRB_SRC_HINT0 = 2'b00,
		IPRB_SRC_HINT1 = 2'b01,
		IPRB_SRC_MOVE  = 2'b10
	} iprb_src_t;
endpackage

// ### core/iprb_port_arbiter.sv
`timescale 1ns/1ps
module iprb_port_arbiter (
	// Requesters
	input  wire logic hint0Valid,
	input  wire logic hint1Valid,
	input  wire logic moveValid,
	// Port selections
	output logic      port0Valid,
	output iprb_pkg::iprb_src_t port0Src,
	output logic      port1Valid,
	output iprb_pkg::iprb_src_t port1Src
);
	import iprb_pkg::*;

	always_comb begin
		port0Valid = 1'b1;
		port1Valid = 1'b0;
		port0Src   = IPRB_SRC_HINT0;
		port1Src   = IPRB_SRC_MOVE;
		// Hints claim port 0 first, bundle 0 ahead of bundle 1.
		if (hint0Valid) begin
			port0Src = IPRB_SRC_HINT0;
			if (moveValid) begin
				port1Valid = 1'b1; // Bundle-1 hint drops when the move is present.
				port1Src   = IPRB_SRC_MOVE;
			end else if (hint1Valid) begin
				port1Valid = 1'b1;
				port1Src   = IPRB_SRC_HINT1;
			end
		end else if (hint1Valid) begin
			port0Src   = IPRB_SRC_HINT1;
			port1Valid = moveValid;
			port1Src   = IPRB_SRC_MOVE;
		end else if (moveValid) begin
			port0Src = IPRB_SRC_MOVE;
		end else begin
			port0Valid = 1'b0; // Nothing to write.
		end
	end
endmodule // iprb_port_arbiter

// ### core/iprb_trace_check.sv
`timescale 1ns/1ps
module iprb_trace_check (
	// Entry state
	input  wire logic [1:0] traceIn,
	input  wire logic [1:0] dcIn,
	input  wire logic [1:0] ageIn,
	// Branch event
	input  wire logic       branchValid,
	input  wire logic       branchTaken,
	// Update
	output logic [1:0]      traceOut,
	output logic [1:0]      dcOut,
	output logic [1:0]      ageOut,
	output logic            mismatch
);
	import iprb_pkg::*;

	always_comb begin
		traceOut = traceIn;
		dcOut    = dcIn;
		ageOut   = ageIn | dcIn; // Don't-care bits count as checked.
		mismatch = 1'b0;
		if (branchValid && !ageOut[0]) begin
			if (traceIn[0] == branchTaken) begin
				traceOut = {1'b0, traceIn[1]};
				dcOut    = {1'b0, dcIn[1]};
				ageOut   = {1'b1, ageOut[1]};
			end else begin
				mismatch = 1'b1;
			end
		end else if (branchValid && !ageOut[1]) begin
			// A don't-care first bit still uses up this branch, so the second bit gets its turn.
			traceOut = {1'b0, traceIn[1]};
			dcOut    = {1'b0, dcIn[1]};
			ageOut   = {1'b1, ageOut[1]};
		end
	end
endmodule // iprb_trace_check

// ### dv/iprb_fe_model.sv
`timescale 1ns/1ps
module iprb_fe_model (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Lookup and mid-level request
	input  wire logic       lookupValid,
	input  wire logic       midReqValid,
	output logic            icacheHit,
	output logic            itlbMiss,
	output logic            midReqReady,
	// Behaviour control
	input  wire logic [1:0] mode,
	input  wire logic [3:0] delay
);
	logic [3:0] waitReg;
	logic       togReg;

	// Outside a lookup the answers toggle, so a stale level is never trusted.
	assign icacheHit = lookupValid ? (mode == 2'h1) : togReg;
	assign itlbMiss  = lookupValid ? (mode == 2'h2) : ~togReg;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			waitReg <= 4'h0;
			togReg <= 1'b0;
			midReqReady <= 1'b0;
		end else begin
			togReg <= ~togReg;
			midReqReady <= 1'b0;
			if (midReqValid && !midReqReady) begin
				waitReg <= waitReg + 4'h1;
				if (waitReg >= delay) begin
					midReqReady <= 1'b1;
					waitReg <= 4'h0;
				end
			end
		end
	end
endmodule // iprb_fe_model

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import iprb_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0;
	logic hint0Valid = 1'b0, hint1Valid = 1'b0, moveValid = 1'b0;
	logic [1:0] hint0Slot = 2'h0, hint1Slot = 2'h0, mode = 2'h1;
	logic [63:0] hint0Addr = 64'h0, hint1Addr = 64'h0, moveAddr = 64'h0;
	iprb_compl_t hint0Compl0 = IPRB_TAKEN, hint0Compl1 = IPRB_TAKEN;
	iprb_compl_t hint1Compl0 = IPRB_TAKEN, hint1Compl1 = IPRB_TAKEN;
	logic branchValid = 1'b0, branchTaken = 1'b0, streamActive = 1'b0;
	logic [1:0] streamTrace = 2'h0, streamDc = 2'h0, s0, s1;
	logic [3:0] delay = 4'h0;
	logic icacheHit, itlbMiss, midReqReady, lookupValid, midReqValid;
	logic streamCancel, cancelPulse, sawMid, sawCancel, sawStream;
	logic [63:0] lookupAddr, midReqAddr, capAddr, a0;
	logic [7:0] entryValid, entryReady;
	int errors = 0, n_checks = 0, cyc = 0, i, r;

	iprb_buffer u_dut (.ref_clk, .nrst, .hint0Valid, .hint0Slot, .hint0Addr, .hint0Compl0,
		.hint0Compl1, .hint1Valid, .hint1Slot, .hint1Addr, .hint1Compl0, .hint1Compl1,
		.moveValid, .moveAddr, .branchValid, .branchTaken, .lookupValid, .lookupAddr,
		.icacheHit, .itlbMiss, .midReqValid, .midReqAddr, .midReqReady, .streamActive,
		.streamTrace, .streamDc, .streamCancel, .entryValid, .entryReady, .cancelPulse);
	iprb_fe_model u_fe (.ref_clk, .nrst, .lookupValid, .midReqValid, .icacheHit, .itlbMiss,
		.midReqReady, .mode, .delay);

	always #20 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Watchers
	// ----------------------------------------
	// Pulses are caught here so a one-cycle output is never missed between checks.
	always @(posedge ref_clk) begin
		cyc++;
		if (midReqValid === 1'b1) begin
			sawMid <= 1'b1;
			capAddr <= midReqAddr;
		end
		if (cancelPulse === 1'b1) sawCancel <= 1'b1;
		if (streamCancel === 1'b1) sawStream <= 1'b1;
		if (cyc == 20000) begin
			errors++;
			$display("mismatch %0t timeout", $time);
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask

	task automatic put(input logic a, b, m, input logic [1:0] t0, t1,
			input iprb_compl_t c0, c1, d0, d1);
		@(posedge ref_clk);
		a0 = {$urandom(), $urandom()};
		hint0Valid <= a;
		hint1Valid <= b;
		moveValid <= m;
		hint0Slot <= t0;
		hint1Slot <= t1;
		hint0Addr <= a0;
		hint1Addr <= {$urandom(), $urandom()};
		moveAddr <= {$urandom(), $urandom()};
		{hint0Compl0, hint0Compl1, hint1Compl0, hint1Compl1} <= {c0, c1, d0, d1};
		@(posedge ref_clk);
		{hint0Valid, hint1Valid, moveValid} <= 3'h0;
		#1;
	endtask

	task automatic branch(input logic tk);
		@(posedge ref_clk);
		branchValid <= 1'b1;
		branchTaken <= tk;
		@(posedge ref_clk);
		branchValid <= 1'b0;
		#1;
	endtask

	task automatic idle();
		int k;
		for (k = 0; k < 40 && !(entryValid === 8'h0 && midReqValid === 1'b0); k++) begin
			@(posedge ref_clk);
			#1;
		end
		// One more edge lets the watchers catch a pulse launched by the last drain.
		@(posedge ref_clk);
		#1;
		chk(64'(entryValid), 64'h0, "drain");
	endtask

	function automatic logic [63:0] cnt(input logic [7:0] v);
		return 64'($countones(v));
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(33424));
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk(64'(entryValid), 64'h0, "reset");
		for (i = 0; i < 24; i++) begin
			s0 = (i < 8) ? 2'h2 : 2'($urandom_range(3));
			s1 = (i < 8) ? 2'h2 : 2'($urandom_range(3));
			r = int'(i[0] && s0 == 2'h2) + int'(i[1] && s1 == 2'h2) + int'(i[2]);
			put(i[0], i[1], i[2], s0, s1, IPRB_TAKEN, IPRB_TAKEN, IPRB_NOT_TAKEN, IPRB_NOT_TAKEN);
			chk(cnt(entryValid), 64'((r > 2) ? 2 : r), "ports");
			branch(1'b1);
			chk(cnt(entryValid), 64'(i[0] && s0 == 2'h2), "drop");
			branch(1'b0);
			idle();
		end
		for (i = 0; i < 5; i++) put(1, 1, 0, 2, 2, IPRB_TAKEN, IPRB_TAKEN, IPRB_TAKEN, IPRB_TAKEN);
		chk(cnt(entryValid), 64'h8, "full");
		branch(1'b0);
		chk(cnt(entryValid), 64'h0, "flush");
		mode = 2'h0;
		sawMid = 1'b0;
		put(1, 0, 0, 2, 2, IPRB_TAKEN, IPRB_NOT_TAKEN, IPRB_TAKEN, IPRB_TAKEN);
		chk(cnt(entryReady), 64'h0, "age0");
		branch(1'b1);
		chk({48'h0, entryReady, entryValid}, 64'h0001, "age1");
		branch(1'b0);
		chk(cnt(entryReady), 64'h1, "age2");
		idle();
		chk(64'(sawMid), 64'h1, "mid");
		chk(capAddr, a0, "addr");
		delay = 4'h5;
		put(1, 0, 0, 2, 2, IPRB_TAKEN, IPRB_DONT_CARE, IPRB_TAKEN, IPRB_TAKEN);
		branch(1'b1);
		chk(cnt(entryReady), 64'h1, "dc");
		idle();
		mode = 2'h1;
		sawMid = 1'b0;
		put(0, 0, 1, 2, 2, IPRB_TAKEN, IPRB_TAKEN, IPRB_TAKEN, IPRB_TAKEN);
		idle();
		chk(64'(sawMid), 64'h0, "hit");
		mode = 2'h2;
		sawCancel = 1'b0;
		put(0, 0, 1, 2, 2, IPRB_TAKEN, IPRB_TAKEN, IPRB_TAKEN, IPRB_TAKEN);
		idle();
		chk(64'({sawMid, sawCancel}), 64'h1, "tlb");
		for (i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			streamActive <= 1'b0;
			streamTrace <= 2'h1;
			@(posedge ref_clk);
			streamActive <= 1'b1;
			#1;
			sawStream = 1'b0;
			branch(i[0]);
			if (i == 1) branch(1'b0);
			repeat (4) @(posedge ref_clk);
			#1;
			chk(64'(sawStream), 64'(i == 0), "stream");
		end
		streamActive <= 1'b0;
		end_of_test();
	end
endmodule // testbench
